// ### logic/dsp_alu_barrel_shifter.sv
/*
 * 36-bit single-cycle arithmetic/logic unit and barrel shifter with four
 * accumulators, shift value, second status and pointer latch registers.
 * Assumes the decoder presents one command per cycle with cmd_valid_i,
 * data bus word, product and pointer values synchronous to clk_i; pointer
 * post-modification is done by the address unit outside.
 */
// Notes on behaviour
// - Arithmetic unit is 36 bits wide, one cycle per operation, unpipelined.
// - First operand from a primary accumulator; result returns to that accumulator.
// - Source operands may be 8, 16 or 36 bits wide.
// - Narrow operands sign-extend for arithmetic, zero-extend for logic operations.
// - Immediate read-modify-write add, subtract, compare take two cycles, accumulators untouched.
// - Flags follow arithmetic and shifter results, reflecting the written accumulator.
// - Rounding adds 0x8000 to the accumulator in one cycle, alone or combined.
// - AND, OR, XOR act on 36 bits with zero-extended narrow operands.
// - Max/min compares two accumulators; new extreme copied to named accumulator.
// - New extreme latches pointer register zero into the 16-bit pointer latch.
// - Memory-maximum compares the word at pointer zero and latches on new maximum.
// - Strict conditions keep first equal element, inclusive ones keep the last.
// - Barrel shifter shifts 36 bits left or right, arithmetic, logic, rotate.
// - Shifter source from any accumulator or aligned bus; result to any accumulator.
// - Immediate shift uses a 6-bit signed count, positive left, negative right.
// - Shift by shift value register is conditional and covers -36 to +36.
// - Differing source and destination leave the source accumulator unchanged.
// - Modify commands give conditional 1-bit shifts and rotates and 4-bit shifts.
// - Left shifts fill zeros; right shifts fill sign or zeros by mode, except 1- and 4-bit modify right shifts, which always fill sign.
// - Bit 7 of the second status register selects arithmetic or logic shifting.
// - Move-and-shift loads any accumulator from the bus shifted by shift value.
// - Load from address pointer register shifts by opcode constant 15 to -16.
// - Accumulator is 16-bit high, 16-bit low and 4-bit extension parts.
`timescale 1ns/1ns
`default_nettype none

`include "dsp_alu_cfg.svh"

module dsp_alu_barrel_shifter #(
   parameter int ACC_W  = `ACC_W,
   parameter int DATA_W = `DATA_W,
   parameter int ADDR_W = `ADDR_W
) (
   input  wire logic                  clk_i,
   input  wire logic                  resetn_i,
   input  wire logic                  cmd_valid_i,
   input  wire dsp_alu_pkg::cmd_t     cmd_i,
   output logic                       cmd_ready_o,
   input  wire logic [DATA_W-1:0]     primary_data_bus_i,
   input  wire logic [ACC_W-1:0]      product_i,
   input  wire logic [DATA_W-1:0]     pointer_reg_zero_i,
   input  wire logic [DATA_W-1:0]     address_pointer_reg_i,
   output logic                       rmw_valid_o,
   output logic [DATA_W-1:0]          rmw_data_o,
   output dsp_alu_pkg::flags_t        flags_o,
   output logic [DATA_W-1:0]          ptr_latch_o,
   input  wire logic [ADDR_W-1:0]     reg_addr_i,
   input  wire logic [DATA_W-1:0]     reg_wdata_i,
   input  wire logic                  reg_wr_i,
   input  wire logic                  reg_rd_i,
   output logic [DATA_W-1:0]          reg_rdata_o
);

   // ************************************************************
   // Functions
   // ************************************************************

   // Align a bus word to 36 bits, sign or zero extended
   function automatic logic [ACC_W-1:0] align(input logic [DATA_W-1:0] w,
                                              input dsp_alu_pkg::opnd_wid_t wid,
                                              input logic sext);
      logic [ACC_W-1:0] r;
      r = '0;
      if (wid == dsp_alu_pkg::WID_8) begin
         r = {{(ACC_W-8){sext & w[7]}}, w[7:0]};
      end else begin
         r = {{(ACC_W-DATA_W){sext & w[DATA_W-1]}}, w};
      end
      return r;
   endfunction

   // Signed count shift: positive left, negative right
   function automatic logic [ACC_W-1:0] shift36(input logic [ACC_W-1:0] v,
                                                input logic signed [7:0] n,
                                                input logic arith);
      logic [6:0]         m;
      logic               fill;
      logic [2*ACC_W-1:0] wide;
      logic [ACC_W-1:0]   r;
      m    = '0;
      fill = arith & v[ACC_W-1];
      wide = '0;
      r    = '0;
      if (n >= 0) begin
         m = n[6:0];
         r = (m >= 7'(ACC_W)) ? '0 : (v << m);
      end else begin
         m    = 7'(-n);
         wide = {{ACC_W{fill}}, v} >> m;
         r    = (m >= 7'(ACC_W)) ? {ACC_W{fill}} : wide[ACC_W-1:0];
      end
      return r;
   endfunction

   // Zero, minus and extension-in-use flags of a 36-bit value
   function automatic dsp_alu_pkg::flags_t flags_of(input logic [ACC_W-1:0] v);
      dsp_alu_pkg::flags_t f;
      f.zero  = (v == '0);
      f.minus = v[ACC_W-1];
      f.ext   = !((v[ACC_W-1:31] == '0) || (v[ACC_W-1:31] == '1));
      return f;
   endfunction

   // Register port hit on accumulator n
   function automatic logic acc_hit(input logic [ADDR_W-1:0] a, input int n);
      return (a[ADDR_W-1:2] == 3'(n)) && (a[1:0] != 2'h3);
   endfunction

   // ************************************************************
   // State
   // ************************************************************

   logic [ACC_W-1:0]      acc_q [`NUM_ACC];
   logic [DATA_W-1:0]     sv_q;
   logic [DATA_W-1:0]     st2_q;
   logic [DATA_W-1:0]     latch_q;
   dsp_alu_pkg::flags_t   flags_q;
   dsp_alu_pkg::state_t   state_q;
   dsp_alu_pkg::state_t   state_d;
   logic [DATA_W-1:0]     rmw_data_q;
   logic                  rmw_wb_q;
   logic [DATA_W-1:0]     rdata_q;

   // ************************************************************
   // Operand selection
   // ************************************************************

   wire logic             take;
   wire logic             arith_mode;
   wire logic             logic_op;
   wire logic [1:0]       pri_idx;
   wire logic [1:0]       oth_idx;
   wire logic [ACC_W-1:0] opa;
   wire logic [ACC_W-1:0] bus_op;
   wire logic [ACC_W-1:0] opb;
   wire logic [ACC_W-1:0] round_add;
   wire logic [ACC_W-1:0] sum;
   wire logic [ACC_W-1:0] diff;
   wire logic [ACC_W-1:0] sh_src;
   wire logic signed [DATA_W-1:0] sv_s;
   wire logic signed [7:0] sv_cnt;
   wire logic signed [7:0] imm_cnt;
   wire logic signed [7:0] ptr_cnt;
   wire logic [ACC_W-1:0] ptr_src;

   assign take       = cmd_valid_i && cmd_ready_o;
   assign arith_mode = !st2_q[`SHIFT_MODE_BIT];
   assign logic_op   = (cmd_i.op == dsp_alu_pkg::OP_AND) || (cmd_i.op == dsp_alu_pkg::OP_OR) ||
                       (cmd_i.op == dsp_alu_pkg::OP_XOR);
   assign pri_idx    = {1'b0, cmd_i.src[0]};
   assign oth_idx    = {1'b0, ~cmd_i.src[0]};
   assign opa        = acc_q[pri_idx];
   assign bus_op     = align(primary_data_bus_i, cmd_i.wid, !logic_op);
   // 8, 16 or 36 bit operand
   assign opb        = (cmd_i.sel == dsp_alu_pkg::SEL_PROD) ? product_i :
                       (cmd_i.sel == dsp_alu_pkg::SEL_BUS)  ? bus_op    : acc_q[oth_idx];
   // Rounding folded into the same add
   assign round_add  = cmd_i.round ? `ROUND_CONST : '0;
   assign sum        = opa + opb + round_add;
   assign diff       = opa - opb + round_add;
   // Shifter source any accumulator or bus
   assign sh_src     = (cmd_i.sel == dsp_alu_pkg::SEL_BUS) ?
                       align(primary_data_bus_i, cmd_i.wid, arith_mode) : acc_q[cmd_i.src];
   assign sv_s       = sv_q;
   assign sv_cnt     = (sv_s >  16'sd36) ?  8'sd36 :
                       (sv_s < -16'sd36) ? -8'sd36 : 8'(sv_s);
   assign imm_cnt    = 8'(signed'(cmd_i.imm[`IMM_SHIFT_W-1:0]));
   // 5-bit signed count for pointer loads
   assign ptr_cnt    = 8'(signed'(cmd_i.imm[`PTR_SHIFT_W-1:0]));
   assign ptr_src    = align(address_pointer_reg_i, dsp_alu_pkg::WID_16, arith_mode);

   // ************************************************************
   // Max/min search
   // ************************************************************

   wire logic [ACC_W-1:0] mm_cur;
   wire logic [ACC_W-1:0] mm_cand;
   wire logic             mm_ge;
   wire logic             mm_gt;
   wire logic             mm_new;

   assign mm_cur  = acc_q[{1'b0, cmd_i.dst[0]}];
   // Memory word at pointer zero as candidate
   assign mm_cand = (cmd_i.op == dsp_alu_pkg::OP_MAXD) ?
                    align(primary_data_bus_i, dsp_alu_pkg::WID_16, 1'b1) : acc_q[{1'b0, ~cmd_i.dst[0]}];
   assign mm_ge   = $signed(mm_cand) >= $signed(mm_cur);
   assign mm_gt   = $signed(mm_cand) >  $signed(mm_cur);
   // Strict keeps first tie, inclusive keeps last
   assign mm_new  = (cmd_i.op == dsp_alu_pkg::OP_MIN) ?
                    (cmd_i.inclusive ? !mm_gt : !mm_ge) :
                    (cmd_i.inclusive ?  mm_ge :  mm_gt);

   // ************************************************************
   // Result selection
   // ************************************************************

   logic                  wr_en;
   logic [1:0]            wr_idx;
   logic [ACC_W-1:0]      wr_val;
   logic                  flag_en;
   logic [ACC_W-1:0]      flag_val;
   logic                  latch_en;
   logic                  rmw_go;
   logic                  rmw_wb;
   logic [DATA_W-1:0]     rmw_val;

   always_comb begin
      wr_en    = 1'b0;
      wr_idx   = pri_idx;
      wr_val   = '0;
      flag_en  = 1'b0;
      flag_val = '0;
      latch_en = 1'b0;
      rmw_go   = 1'b0;
      rmw_wb   = 1'b0;
      rmw_val  = '0;
      if (take) begin
         case (cmd_i.op)
            dsp_alu_pkg::OP_ADD: begin
               wr_en  = 1'b1;
               wr_val = sum;
            end
            dsp_alu_pkg::OP_SUB: begin
               wr_en  = 1'b1;
               wr_val = diff;
            end
            dsp_alu_pkg::OP_CMP: begin
               flag_en  = 1'b1;
               flag_val = opa - opb;
            end
            dsp_alu_pkg::OP_AND: begin
               wr_en  = 1'b1;
               wr_val = opa & opb;
            end
            dsp_alu_pkg::OP_OR: begin
               wr_en  = 1'b1;
               wr_val = opa | opb;
            end
            dsp_alu_pkg::OP_XOR: begin
               wr_en  = 1'b1;
               wr_val = opa ^ opb;
            end
            dsp_alu_pkg::OP_RND: begin
               wr_en  = 1'b1;
               wr_val = opa + `ROUND_CONST;
            end
            // Copy new extreme to named accumulator
            dsp_alu_pkg::OP_MAX, dsp_alu_pkg::OP_MIN, dsp_alu_pkg::OP_MAXD: begin
               wr_idx   = {1'b0, cmd_i.dst[0]};
               wr_en    = mm_new;
               wr_val   = mm_cand;
               latch_en = mm_new;
            end
            dsp_alu_pkg::OP_SHFI: begin
               wr_idx = cmd_i.dst;
               wr_en  = 1'b1;
               wr_val = shift36(sh_src, imm_cnt, arith_mode);
            end
            dsp_alu_pkg::OP_SHFC: begin
               wr_idx = cmd_i.dst;
               wr_en  = cmd_i.cond;
               wr_val = shift36(sh_src, sv_cnt, arith_mode);
            end
            dsp_alu_pkg::OP_SHL1: begin
               wr_idx = cmd_i.src;
               wr_en  = cmd_i.cond;
               wr_val = shift36(acc_q[cmd_i.src], 8'sd1, 1'b1);
            end
            dsp_alu_pkg::OP_SHR1: begin
               wr_idx = cmd_i.src;
               wr_en  = cmd_i.cond;
               wr_val = shift36(acc_q[cmd_i.src], -8'sd1, 1'b1);
            end
            dsp_alu_pkg::OP_ROL1: begin
               wr_idx = cmd_i.src;
               wr_en  = cmd_i.cond;
               wr_val = {acc_q[cmd_i.src][ACC_W-2:0], acc_q[cmd_i.src][ACC_W-1]};
            end
            dsp_alu_pkg::OP_ROR1: begin
               wr_idx = cmd_i.src;
               wr_en  = cmd_i.cond;
               wr_val = {acc_q[cmd_i.src][0], acc_q[cmd_i.src][ACC_W-1:1]};
            end
            dsp_alu_pkg::OP_SHL4: begin
               wr_idx = cmd_i.src;
               wr_en  = cmd_i.cond;
               wr_val = shift36(acc_q[cmd_i.src], 8'sd4, 1'b1);
            end
            dsp_alu_pkg::OP_SHR4: begin
               wr_idx = cmd_i.src;
               wr_en  = cmd_i.cond;
               wr_val = shift36(acc_q[cmd_i.src], -8'sd4, 1'b1);
            end
            // Bus word shifted by shift value
            dsp_alu_pkg::OP_MOVS: begin
               wr_idx = cmd_i.dst;
               wr_en  = 1'b1;
               wr_val = shift36(align(primary_data_bus_i, dsp_alu_pkg::WID_16, arith_mode),
                                sv_cnt, arith_mode);
            end
            dsp_alu_pkg::OP_MOVSI: begin
               wr_idx = cmd_i.dst;
               wr_en  = 1'b1;
               wr_val = shift36(ptr_src, ptr_cnt, arith_mode);
            end
            // Immediate against bus word, no accumulator write
            dsp_alu_pkg::OP_ADDV: begin
               rmw_go  = 1'b1;
               rmw_wb  = 1'b1;
               rmw_val = primary_data_bus_i + cmd_i.imm;
            end
            dsp_alu_pkg::OP_SUBV: begin
               rmw_go  = 1'b1;
               rmw_wb  = 1'b1;
               rmw_val = primary_data_bus_i - cmd_i.imm;
            end
            dsp_alu_pkg::OP_CMPV: begin
               rmw_go  = 1'b1;
               rmw_val = primary_data_bus_i - cmd_i.imm;
            end
            default: begin
               wr_en = 1'b0;
            end
         endcase
         if (wr_en) begin
            flag_en  = 1'b1;
            flag_val = wr_val;
         end
      end
   end

   // ************************************************************
   // Accumulators
   // ************************************************************

   wire logic             bus_wr_acc;

   assign bus_wr_acc = reg_wr_i && (reg_addr_i[1:0] != 2'h3) && (reg_addr_i < `OFS_SHIFT_VALUE);

   // Only the destination accumulator is written
   for (genvar n = 0; n < `NUM_ACC; n++) begin : g_acc
      wire logic dp_hit;
      wire logic bus_hit;

      assign dp_hit  = wr_en && (wr_idx == 2'(n));
      assign bus_hit = bus_wr_acc && acc_hit(reg_addr_i, n);

      always_ff @(posedge clk_i or negedge resetn_i) begin
         if (!resetn_i) begin
            acc_q[n] <= `RST_ACC;
         end else if (dp_hit) begin
            acc_q[n] <= wr_val;
         end else if (bus_hit) begin
            case (reg_addr_i[1:0])
               `ACC_PART_LOW:  acc_q[n] <= {20'h00000, reg_wdata_i};
               `ACC_PART_HIGH: acc_q[n] <= {{4{reg_wdata_i[DATA_W-1]}}, reg_wdata_i, 16'h0000};
               `ACC_PART_EXT:  acc_q[n] <= {reg_wdata_i[3:0], acc_q[n][31:0]};
               default:        acc_q[n] <= acc_q[n];
            endcase
         end
      end
   end

   // ************************************************************
   // Read-modify-write sequencer
   // ************************************************************

   always_comb begin
      case (state_q)
         dsp_alu_pkg::ST_IDLE: state_d = rmw_go ? dsp_alu_pkg::ST_RMW : dsp_alu_pkg::ST_IDLE;
         dsp_alu_pkg::ST_RMW:  state_d = dsp_alu_pkg::ST_IDLE;
         default:              state_d = dsp_alu_pkg::ST_IDLE;
      endcase
   end

   // Second cycle holds off new commands
   assign cmd_ready_o = (state_q == dsp_alu_pkg::ST_IDLE);
   assign rmw_valid_o = (state_q == dsp_alu_pkg::ST_RMW) && rmw_wb_q;
   assign rmw_data_o  = rmw_data_q;
   assign flags_o     = flags_q;
   assign ptr_latch_o = latch_q;
   assign reg_rdata_o = rdata_q;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q    <= dsp_alu_pkg::ST_IDLE;
         rmw_data_q <= `RST_DATA;
         rmw_wb_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         if (rmw_go) begin
            rmw_data_q <= rmw_val;
            rmw_wb_q   <= rmw_wb;
         end
      end
   end

   // ************************************************************
   // Flags, pointer latch and register port
   // ************************************************************

   wire logic [DATA_W-1:0] rd_mux;
   wire logic [ACC_W-1:0]  rd_acc;

   assign rd_acc = acc_q[reg_addr_i[3:2]];
   assign rd_mux = (reg_addr_i == `OFS_SHIFT_VALUE) ? sv_q    :
                   (reg_addr_i == `OFS_STATUS_TWO)  ? st2_q   :
                   (reg_addr_i == `OFS_PTR_LATCH)   ? latch_q :
                   (reg_addr_i == `OFS_FLAGS)       ? {13'h0000, flags_q} :
                   (reg_addr_i >= `OFS_SHIFT_VALUE) ? `RST_DATA :
                   (reg_addr_i[1:0] == `ACC_PART_LOW)  ? rd_acc[15:0]  :
                   (reg_addr_i[1:0] == `ACC_PART_HIGH) ? rd_acc[31:16] :
                   (reg_addr_i[1:0] == `ACC_PART_EXT)  ? {12'h000, rd_acc[35:32]} : `RST_DATA;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         flags_q <= '0;
         latch_q <= `RST_DATA;
         sv_q    <= `RST_DATA;
         st2_q   <= `RST_DATA;
         rdata_q <= `RST_DATA;
      end else begin
         if (flag_en) begin
            flags_q <= flags_of(flag_val);
         end else if (rmw_go) begin
            flags_q <= flags_of(align(rmw_val, dsp_alu_pkg::WID_16, 1'b1));
         end
         if (latch_en) begin
            latch_q <= pointer_reg_zero_i;
         end
         if (reg_wr_i && (reg_addr_i == `OFS_SHIFT_VALUE)) begin
            sv_q <= reg_wdata_i;
         end
         if (reg_wr_i && (reg_addr_i == `OFS_STATUS_TWO)) begin
            st2_q <= reg_wdata_i;
         end
         rdata_q <= reg_rd_i ? rd_mux : `RST_DATA;
      end
   end

endmodule // dsp_alu_barrel_shifter

`default_nettype wire

// ### logic/dsp_alu_cfg.svh
/*
 * Constants of the 36-bit datapath: widths, register-port indices,
 * field positions, reset values and fixed operands.
 * Assumes inclusion by bare name from the package and the datapath.
 */
`ifndef DSP_ALU_CFG_SVH
`define DSP_ALU_CFG_SVH

`define ACC_W            36
`define DATA_W           16
`define ADDR_W           5
`define NUM_ACC          4
`define SHIFT_MAX        36
`define ROUND_CONST      36'h000008000
`define SHIFT_MODE_BIT   7
`define IMM_SHIFT_W      6
`define PTR_SHIFT_W      5

// Register port indices: accumulator n part p sits at n*4+p
`define ACC_PART_LOW     2'h0
`define ACC_PART_HIGH    2'h1
`define ACC_PART_EXT     2'h2
`define OFS_SHIFT_VALUE  5'h10
`define OFS_STATUS_TWO   5'h11
`define OFS_PTR_LATCH    5'h12
`define OFS_FLAGS        5'h13

`define RST_ACC          36'h000000000
`define RST_DATA         16'h0000

`endif

// ### logic/dsp_alu_pkg.sv
/*
 * Types shared by the datapath and its bench: operation codes,
 * operand selection, command and flag carriers.
 * Assumes dsp_alu_cfg.svh is on the include path.
 */
`include "dsp_alu_cfg.svh"

package dsp_alu_pkg;

   typedef enum logic [4:0] {
      OP_NOP,   OP_ADD,   OP_SUB,   OP_CMP,   OP_AND,   OP_OR,    OP_XOR,   OP_RND,
      OP_MAX,   OP_MIN,   OP_MAXD,  OP_SHFI,  OP_SHFC,  OP_SHL1,  OP_SHR1,  OP_ROL1,
      OP_ROR1,  OP_SHL4,  OP_SHR4,  OP_MOVS,  OP_MOVSI, OP_ADDV,  OP_SUBV,  OP_CMPV
   } op_t;

   typedef enum logic [1:0] {
      SEL_ACC  = 2'h0,
      SEL_PROD = 2'h1,
      SEL_BUS  = 2'h2
   } opnd_sel_t;

   typedef enum logic [1:0] {
      WID_8  = 2'h0,
      WID_16 = 2'h1,
      WID_36 = 2'h2
   } opnd_wid_t;

   typedef struct packed {
      op_t                   op;
      logic [1:0]            src;
      logic [1:0]            dst;
      opnd_sel_t             sel;
      opnd_wid_t             wid;
      logic                  inclusive;
      logic                  round;
      logic                  cond;
      logic [`DATA_W-1:0]    imm;
   } cmd_t;

   typedef struct packed {
      logic ext;
      logic minus;
      logic zero;
   } flags_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RMW  = 2'b01
   } state_t;

endpackage : dsp_alu_pkg

// ### dv/dsp_alu_chk_sva.sv
/* Port checker for the 36-bit datapath.
   Assumes binding to dsp_alu_barrel_shifter, one clock domain. */
`timescale 1ns/1ns
`default_nettype none
module dsp_alu_chk #(parameter int DATA_W = 16) (
   input wire logic               clk_i,
   input wire logic               resetn_i,
   input wire logic               cmd_valid_i,
   input wire dsp_alu_pkg::cmd_t  cmd_i,
   input wire logic               cmd_ready_o,
   input wire logic [DATA_W-1:0]  primary_data_bus_i,
   input wire logic               rmw_valid_o,
   input wire logic [DATA_W-1:0]  rmw_data_o,
   input wire dsp_alu_pkg::flags_t flags_o,
   input wire logic [DATA_W-1:0]  ptr_latch_o,
   input wire logic               reg_rd_i,
   input wire logic [DATA_W-1:0]  reg_rdata_o
);
   // ****
   // Checks
   // ****
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   wire take = cmd_valid_i && cmd_ready_o;
   wire rmw_w = take && cmd_i.op inside {dsp_alu_pkg::OP_ADDV, dsp_alu_pkg::OP_SUBV, dsp_alu_pkg::OP_CMPV};
   wire extr_w = take && cmd_i.op inside {dsp_alu_pkg::OP_MAX, dsp_alu_pkg::OP_MIN, dsp_alu_pkg::OP_MAXD};
   sequence rmw_take; rmw_w; endsequence
   sequence one_bubble; !cmd_ready_o ##1 cmd_ready_o; endsequence
   rmw_stall_a: assert property (rmw_take |=> one_bubble)
      else $error("no single bubble after rmw");
   addv_data_a: assert property (take && cmd_i.op == dsp_alu_pkg::OP_ADDV |=>
      rmw_valid_o && rmw_data_o == $past(primary_data_bus_i) + $past(cmd_i.imm)) else $error("addv result");
   cmpv_quiet_a: assert property (take && cmd_i.op == dsp_alu_pkg::OP_CMPV |=> !rmw_valid_o)
      else $error("cmpv wrote back");
   valid_pulse_a: assert property (rmw_valid_o |=> !rmw_valid_o) else $error("rmw valid too long");
   stall_cause_a: assert property (!cmd_ready_o |-> $past(rmw_w)) else $error("stall without rmw");
   latch_cause_a: assert property (!$stable(ptr_latch_o) |-> $past(extr_w))
      else $error("pointer latch moved");
   cond_skip_a: assert property (take && cmd_i.op == dsp_alu_pkg::OP_SHFC && !cmd_i.cond |=> $stable(flags_o))
      else $error("skipped shift touched flags");
   rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == '0) else $error("read data not idle");
endmodule // dsp_alu_chk
bind dsp_alu_barrel_shifter dsp_alu_chk #(.DATA_W(DATA_W)) u_chk (.clk_i(clk_i), .resetn_i(resetn_i),
   .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .primary_data_bus_i(primary_data_bus_i),
   .rmw_valid_o(rmw_valid_o), .rmw_data_o(rmw_data_o), .flags_o(flags_o), .ptr_latch_o(ptr_latch_o),
   .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
`default_nettype wire

// ### dv/dsp_core_model.sv
/* Address unit model: pointer zero, post-modified on each extreme search.
   Assumes the core clock and reset of the datapath. */
`timescale 1ns/1ns
`default_nettype none
module dsp_core_model #(parameter logic [15:0] PTR_START = 16'h0100) (
   input wire logic         clk_i,
   input wire logic         resetn_i,
   input wire logic         step_i,
   output logic [15:0]      ptr_o
);
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) ptr_o <= PTR_START;
      else if (step_i) ptr_o <= ptr_o + 16'h0001;
   end
endmodule // dsp_core_model
`default_nettype wire

// ### dv/dsp_alu_barrel_shifter_tb_top.sv
/* Directed bench for the datapath.
   Assumes the package, checker and address unit model are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module dsp_alu_barrel_shifter_tb_top;
   logic clk_i = 0, resetn = 0, cmd_valid = 0, wr = 0, rd = 0, ready, rmw_v;
   logic [4:0] addr = 0;
   logic [15:0] bus = 0, wdata = 0, aptr = 0, ptr, rmw_d, latch, rdata;
   logic [35:0] prod = 0;
   dsp_alu_pkg::cmd_t cmd = '0;
   dsp_alu_pkg::flags_t flags;
   int bad_count = 0, n_checks = 0;
   wire step = cmd_valid && ready && cmd.op inside {dsp_alu_pkg::OP_MAX, dsp_alu_pkg::OP_MIN, dsp_alu_pkg::OP_MAXD};
   dsp_alu_barrel_shifter u_dut (.clk_i(clk_i), .resetn_i(resetn), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
      .cmd_ready_o(ready), .primary_data_bus_i(bus), .product_i(prod), .pointer_reg_zero_i(ptr),
      .address_pointer_reg_i(aptr), .rmw_valid_o(rmw_v), .rmw_data_o(rmw_d), .flags_o(flags),
      .ptr_latch_o(latch), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata));
   dsp_core_model u_model (.clk_i(clk_i), .resetn_i(resetn), .step_i(step), .ptr_o(ptr));
   initial forever #2 clk_i = ~clk_i;
   // ****
   // Bus tasks
   // ****
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [4:0] a, input logic [15:0] v);
      @(posedge clk_i); wr <= 1'b1; addr <= a; wdata <= v;
      @(posedge clk_i); wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
      @(posedge clk_i); rd <= 1'b1; addr <= a;
      @(posedge clk_i); rd <= 1'b0;
      #1 chk(rdata, e);
   endtask
   // Shift by register is always sent with its condition false
   task automatic op(input dsp_alu_pkg::op_t o, input logic [1:0] s, d, input dsp_alu_pkg::opnd_sel_t sl,
                     input logic inc, input logic [15:0] m, b);
      @(posedge clk_i); cmd_valid <= 1'b1; bus <= b;
      cmd <= '{op:o, src:s, dst:d, sel:sl, wid:dsp_alu_pkg::WID_16, inclusive:inc, round:1'b0,
               cond:(o != dsp_alu_pkg::OP_SHFC), imm:m};
      @(posedge clk_i); cmd_valid <= 1'b0;
   endtask
   // ****
   // Scenarios
   // ****
   task automatic s_arith;
      rd_chk(5'h1f, 16'h0000);
      wr_reg(5'h00, 16'h0005);
      op(dsp_alu_pkg::OP_ADD, 0, 0, dsp_alu_pkg::SEL_BUS, 0, 0, 16'hfffe);
      rd_chk(5'h00, 16'h0003);
      rd_chk(5'h01, 16'h0000);
      op(dsp_alu_pkg::OP_RND, 0, 0, dsp_alu_pkg::SEL_ACC, 0, 0, 0);
      rd_chk(5'h00, 16'h8003);
      op(dsp_alu_pkg::OP_XOR, 0, 0, dsp_alu_pkg::SEL_BUS, 0, 0, 16'hffff);
      rd_chk(5'h00, 16'h7ffc);
      rd_chk(5'h01, 16'h0000);
   endtask
   task automatic s_shift;
      wr_reg(5'h09, 16'h8000);
      wr_reg(5'h11, 16'h0000);
      op(dsp_alu_pkg::OP_SHFI, 2, 3, dsp_alu_pkg::SEL_ACC, 0, 16'h003c, 0);
      rd_chk(5'h0d, 16'hf800);
      rd_chk(5'h0e, 16'h000f);
      rd_chk(5'h09, 16'h8000);
      wr_reg(5'h11, 16'h0080);
      op(dsp_alu_pkg::OP_SHFI, 2, 3, dsp_alu_pkg::SEL_ACC, 0, 16'h003c, 0);
      rd_chk(5'h0e, 16'h0000);
      op(dsp_alu_pkg::OP_ROL1, 3, 3, dsp_alu_pkg::SEL_ACC, 0, 0, 0);
      rd_chk(5'h0e, 16'h0001);
      op(dsp_alu_pkg::OP_SHFC, 3, 0, dsp_alu_pkg::SEL_ACC, 0, 0, 0);
      rd_chk(5'h00, 16'h7ffc);
   endtask
   task automatic s_rmw;
      op(dsp_alu_pkg::OP_ADDV, 0, 0, dsp_alu_pkg::SEL_BUS, 0, 16'h0005, 16'h0010);
      #1 chk(rmw_d, 16'h0015);
      op(dsp_alu_pkg::OP_CMPV, 0, 0, dsp_alu_pkg::SEL_BUS, 0, 16'h0005, 16'h0010);
      rd_chk(5'h00, 16'h7ffc);
   endtask
   task automatic s_max;
      wr_reg(5'h00, 16'h0005);
      wr_reg(5'h04, 16'h0009);
      op(dsp_alu_pkg::OP_MAX, 0, 0, dsp_alu_pkg::SEL_ACC, 0, 0, 0);
      #1 chk(latch, 16'h0100);
      rd_chk(5'h00, 16'h0009);
      op(dsp_alu_pkg::OP_MAX, 0, 0, dsp_alu_pkg::SEL_ACC, 0, 0, 0);
      #1 chk(latch, 16'h0100);
      op(dsp_alu_pkg::OP_MAX, 0, 0, dsp_alu_pkg::SEL_ACC, 1, 0, 0);
      #1 chk(latch, 16'h0102);
   endtask
   // Product operand, flags and pointer register load
   task automatic s_misc;
      @(posedge clk_i);
      prod <= 36'h000010000;
      aptr <= 16'h8001;
      op(dsp_alu_pkg::OP_SUB, 1, 1, dsp_alu_pkg::SEL_PROD, 0, 0, 0);
      #1 chk({13'h0000, flags}, 16'h0002);
      rd_chk(5'h05, 16'hffff);
      op(dsp_alu_pkg::OP_MOVSI, 0, 2, dsp_alu_pkg::SEL_ACC, 0, 16'h000f, 0);
      rd_chk(5'h09, 16'h4000);
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #4000;
      bad_count++;
      print_verdict();
   end
   initial begin
      repeat (5) @(posedge clk_i);
      resetn <= 1'b1;
      s_arith();
      s_shift();
      s_rmw();
      s_max();
      s_misc();
      print_verdict();
   end
endmodule // dsp_alu_barrel_shifter_tb_top
`default_nettype wire
